//--- tb.sv
// Purpose: Self-checking bench for the compare-output timer
// Assumes: APB answers with one wait state; ticks driven by the bench
// Notes: Prescale factor is one, so a tick is one system clock
`timescale 1ns/100ps
module tb;
   logic clk_sys_i = 1'b0;
   logic nrst_i = 1'b0;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic timer_tick_i = 1'b0;
   logic [7:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0000_0000;
   logic [3:0] isr_ack_i = 4'h0;
   logic [31:0] prdata_o, rd;
   logic pready_o, pslverr_o, err;
   logic [3:0] flags_o;
   logic [1:0] oc_pin_o, oc_pin_oe_o, pad;
   logic [1:0] seen [0:7];
   logic [1:0] fa [0:5] = '{2'h3, 2'h2, 2'h1, 2'h1, 2'h3, 2'h0};
   logic [1:0] fe [0:5] = '{2'h1, 2'h0, 2'h1, 2'h0, 2'h1, 2'h0};
   int err_total = 0;
   int num_checks = 0;
   int i, k;

   // ==========================================================
   // Design and pads
   tcm_timer dut_u (.clk_sys_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
      .prdata_o, .pready_o, .pslverr_o, .timer_tick_i, .isr_ack_i, .flags_o, .oc_pin_o, .oc_pin_oe_o);
   tcm_pad_model pad_u (.pin_i(oc_pin_o), .oe_i(oc_pin_oe_o), .pad_o(pad));

   // 125 MHz system clock
   initial
   begin
      forever #4 clk_sys_i = ~clk_sys_i;
   end

   // ==========================================================
   // Tasks
   // Verdict and end of run, also reached by a timeout
   task automatic wrap_up();
      if (err_total == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Compare seen against expected
   task automatic chk(input logic [32:0] s, input logic [32:0] e);
      num_checks++;
      if (s !== e)
      begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask

   // One APB transfer; held until pready is seen, released at that edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      penable_i <= 1'b0;
      @(posedge clk_sys_i);
      penable_i <= 1'b1;
      // Sample pready at each rising edge; request stands until then
      do
      begin
         @(posedge clk_sys_i);
         n++;
      end
      while (pready_o !== 1'b1 && n < 20);
      if (pready_o !== 1'b1)
      begin
         err_total++;
         wrap_up();
      end
      else
      begin
         rd = prdata_o;
         err = pslverr_o;
         psel_i <= 1'b0;
         penable_i <= 1'b0;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      apb(1'b1, a, {16'h0000, d});
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk({err, rd}, {17'h0_0000, e});
   endtask

   // n timer ticks on consecutive clocks
   task automatic ticks(input int n);
      @(posedge clk_sys_i);
      timer_tick_i <= 1'b1;
      repeat (n - 1) @(posedge clk_sys_i);
      @(posedge clk_sys_i);
      timer_tick_i <= 1'b0;
   endtask

   // Pads lag the latch, so let them settle first
   task automatic pins(input logic [1:0] e);
      repeat (3) @(negedge clk_sys_i);
      chk(pad, e);
   endtask

   // ==========================================================
   // Main sequence
   initial
   begin
      repeat (3) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      @(negedge clk_sys_i);
      chk({flags_o, oc_pin_o, oc_pin_oe_o}, 8'h00);
      apb(1'b0, 8'h20, 32'h0000_0000);
      chk({err, rd}, {1'b1, 32'h0000_0000});
      // Port drives the pins while no action is set
      wr(tcm_pkg::ADDR_PORT, 16'h0003);
      pins(2'h3);
      chk(oc_pin_oe_o, 2'h0);
      wr(tcm_pkg::ADDR_PORT, 16'h000c);
      pins(2'h0);
      chk(oc_pin_oe_o, 2'h3);
      // Forced compare through every action, ticks stopped
      for (i = 0; i < 6; i++)
      begin
         wr(tcm_pkg::ADDR_CTRL, {10'h000, fa[i], 4'h0});
         wr(tcm_pkg::ADDR_FORCE, 16'h0001);
         pins(fe[i]);
      end
      wr(tcm_pkg::ADDR_CTRL, 16'h0010);
      pins(2'h1);
      rdchk(tcm_pkg::ADDR_FLAGS, 16'h0000);
      rdchk(tcm_pkg::ADDR_COUNT, 16'h0000);
      // Other modes hold the counter and ignore force
      wr(tcm_pkg::ADDR_CTRL, 16'h0011);
      wr(tcm_pkg::ADDR_COUNT, 16'h0007);
      ticks(3);
      wr(tcm_pkg::ADDR_FORCE, 16'h0001);
      rdchk(tcm_pkg::ADDR_COUNT, 16'h0007);
      pins(2'h1);
      // Normal mode wrap and overflow
      wr(tcm_pkg::ADDR_CTRL, 16'h0000);
      wr(tcm_pkg::ADDR_COUNT, 16'hfffe);
      ticks(1);
      rdchk(tcm_pkg::ADDR_COUNT, 16'hffff);
      rdchk(tcm_pkg::ADDR_FLAGS, 16'h0000);
      ticks(1);
      rdchk(tcm_pkg::ADDR_COUNT, 16'h0000);
      rdchk(tcm_pkg::ADDR_FLAGS, 16'h0001);
      chk(flags_o, 4'h1);
      @(posedge clk_sys_i);
      isr_ack_i <= 4'h1;
      @(posedge clk_sys_i);
      isr_ack_i <= 4'h0;
      rdchk(tcm_pkg::ADDR_FLAGS, 16'h0000);
      // Counter write blocks matches on the next tick only
      wr(tcm_pkg::ADDR_CMPA, 16'h0005);
      wr(tcm_pkg::ADDR_COUNT, 16'h0005);
      ticks(1);
      rdchk(tcm_pkg::ADDR_COUNT, 16'h0006);
      rdchk(tcm_pkg::ADDR_FLAGS, 16'h0000);
      wr(tcm_pkg::ADDR_COUNT, 16'h0004);
      ticks(2);
      rdchk(tcm_pkg::ADDR_FLAGS, 16'h0002);
      wr(tcm_pkg::ADDR_FLAGS, 16'h0002);
      rdchk(tcm_pkg::ADDR_FLAGS, 16'h0000);
      // Clear on compare A with toggle
      wr(tcm_pkg::ADDR_CMPA, 16'h0003);
      wr(tcm_pkg::ADDR_CTRL, 16'h0014);
      wr(tcm_pkg::ADDR_COUNT, 16'h0000);
      ticks(3);
      rdchk(tcm_pkg::ADDR_COUNT, 16'h0003);
      pins(2'h1);
      ticks(1);
      rdchk(tcm_pkg::ADDR_COUNT, 16'h0000);
      rdchk(tcm_pkg::ADDR_FLAGS, 16'h0002);
      pins(2'h0);
      // Top written below the count: run through the wrap first
      wr(tcm_pkg::ADDR_FLAGS, 16'h000f);
      wr(tcm_pkg::ADDR_COUNT, 16'h0005);
      ticks(65531);
      rdchk(tcm_pkg::ADDR_COUNT, 16'h0000);
      rdchk(tcm_pkg::ADDR_FLAGS, 16'h0001);
      ticks(4);
      // Compare B still holds zero, so passing zero raises its flag too
      rdchk(tcm_pkg::ADDR_FLAGS, 16'h0007);
      // Clear on the capture register value
      wr(tcm_pkg::ADDR_FLAGS, 16'h000f);
      wr(tcm_pkg::ADDR_CMPA, 16'h00ff);
      wr(tcm_pkg::ADDR_CAPT, 16'h0002);
      wr(tcm_pkg::ADDR_CTRL, 16'h001c);
      wr(tcm_pkg::ADDR_COUNT, 16'h0000);
      ticks(3);
      rdchk(tcm_pkg::ADDR_COUNT, 16'h0000);
      rdchk(tcm_pkg::ADDR_FLAGS, 16'h0008);
      // Toggle half period is 1+top ticks, for top 0 and 2
      for (k = 0; k < 3; k += 2)
      begin
         wr(tcm_pkg::ADDR_CMPA, k[15:0]);
         wr(tcm_pkg::ADDR_CTRL, 16'h0014);
         // Preload max so the blocked first tick is spent on the wrap, not on a missed top
         wr(tcm_pkg::ADDR_COUNT, 16'hffff);
         @(posedge clk_sys_i);
         timer_tick_i <= 1'b1;
         repeat (6) @(negedge clk_sys_i);
         for (i = 0; i < 8; i++)
         begin
            @(negedge clk_sys_i);
            seen[i] = pad;
         end
         @(posedge clk_sys_i);
         timer_tick_i <= 1'b0;
         for (i = 0; i + k + 1 < 8; i++)
            chk(seen[i] ^ seen[i + k + 1], 2'h1);
      end
      wrap_up();
   end
endmodule

//--- tcm_pad_model.sv
// Purpose: Pad model for the two compare pins beyond the port
// Assumes: A weak pull-up sits on each pad
// Notes: A released pad reads high, never the last driven value
`timescale 1ns/100ps
module tcm_pad_model
(
   // From the timer
   input wire logic [1:0] pin_i,
   input wire logic [1:0] oe_i,
   // Pad level
   output logic [1:0] pad_o
);
   // Driven pads follow the pin; released ones float up to the pull-up
   assign pad_o = (pin_i & oe_i) | ~oe_i;
endmodule

//--- tcm_pkg.sv
// Purpose: Shared constants and types for the compare-output timer block
// Assumes: 32-bit APB, word-aligned registers, 16-bit counter
// Notes: Register offsets are byte addresses on the APB bus
package tcm_pkg;

   // ==========================================================
   // Register map
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_COUNT = 8'h04;
   localparam logic [7:0] ADDR_CMPA = 8'h08;
   localparam logic [7:0] ADDR_CMPB = 8'h0c;
   localparam logic [7:0] ADDR_CAPT = 8'h10;
   localparam logic [7:0] ADDR_FLAGS = 8'h14;
   localparam logic [7:0] ADDR_FORCE = 8'h18;
   localparam logic [7:0] ADDR_PORT = 8'h1c;

   // ==========================================================
   // Counter values and waveform modes
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [15:0] CNT_MAX = 16'hffff;
   localparam logic [15:0] CNT_ONE = 16'h0001;
   localparam logic [3:0] MODE_NORMAL = 4'h0;
   localparam logic [3:0] MODE_CTC_CMPA = 4'h4;
   localparam logic [3:0] MODE_CTC_CAPT = 4'hc;

   // ==========================================================
   // Output action codes
   localparam logic [1:0] ACT_NONE = 2'h0;
   localparam logic [1:0] ACT_TOGGLE = 2'h1;
   localparam logic [1:0] ACT_CLEAR = 2'h2;
   localparam logic [1:0] ACT_SET = 2'h3;

   // ==========================================================
   // Flag bit positions and reset values
   localparam int FLG_OVF = 0;
   localparam int FLG_CMPA = 1;
   localparam int FLG_CMPB = 2;
   localparam int FLG_CAPT = 3;
   localparam logic [3:0] FLAGS_RST = 4'h0;
   localparam logic [1:0] LATCH_RST = 2'h0;
   localparam logic [31:0] RDATA_RST = 32'h0000_0000;

   // Control register: output actions and waveform mode
   typedef struct packed {
      logic [1:0] act_b;
      logic [1:0] act_a;
      logic [3:0] mode;
   } tcm_ctrl_t;

   // Port fallback: pin directions and plain port outputs
   typedef struct packed {
      logic [1:0] dir;
      logic [1:0] out;
   } tcm_port_t;

   // Bus slave states, one-hot
   typedef enum logic [2:0] {
      BUS_IDLE = 3'b001,
      BUS_WAIT = 3'b010,
      BUS_DONE = 3'b100
   } tcm_bus_t;

endpackage

//--- tcm_timer.sv
// Purpose: Compare-match output stage with normal and clear-on-match counting
// Assumes: timer_tick_i is a one-cycle enable from a prescaler on clk_sys_i
// Notes: PWM modes are handled elsewhere; the counter holds in them
`timescale 1ns/100ps

// Overview of operation
// - Reset clears both output latches
// - Nonzero action routes latch onto pin
// - Pin direction always from direction bit
// - Action field never touches capture logic
// - Action zero leaves latch unchanged
// - New action acts from next match
// - Force strobe applies action immediately
// - Counting depends only on waveform mode
// - Action sets, clears or toggles latch
// - Mode 0 counts up, wraps at max
// - Overflow flag set as counter wraps from max to zero
// - Interrupt execution clears overflow flag
// - Counter writable any time in normal
// - Modes 4/12 clear on compare/capture match
// - Top match sets compare or capture flag
// - Unbuffered top; missed match wraps via max
// - Toggle action inverts latch each match
// - Toggle period is 2*N*(1+top) clocks
// - Clear-on-match overflow at max to zero
// - Match sets channel flag; ack or W1C clears
// - Counter write blocks next tick's matches
// - Force touches only the latch
module tcm_timer
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Timer clock enable and interrupt execution acknowledges
   input wire logic timer_tick_i,
   input wire logic [3:0] isr_ack_i,
   // Flags and compare pins
   output logic [3:0] flags_o,
   output logic [1:0] oc_pin_o,
   output logic [1:0] oc_pin_oe_o
);

   // ==========================================================
   // Functions

   // Latch value after one output action
   function automatic logic apply_act(input logic [1:0] act, input logic cur);
      logic r;
      r = cur;
      case (act)
         tcm_pkg::ACT_TOGGLE: r = ~cur;
         tcm_pkg::ACT_CLEAR: r = 1'b0;
         tcm_pkg::ACT_SET: r = 1'b1;
         default: r = cur;
      endcase
      return r;
   endfunction

   // Modes this block counts in
   function automatic logic non_pwm(input logic [3:0] m);
      return (m == tcm_pkg::MODE_NORMAL) || (m == tcm_pkg::MODE_CTC_CMPA) || (m == tcm_pkg::MODE_CTC_CAPT);
   endfunction

   // ==========================================================
   // State

   tcm_pkg::tcm_ctrl_t ctrl;
   tcm_pkg::tcm_port_t port;
   tcm_pkg::tcm_bus_t bus_state;
   logic [15:0] count;
   logic [15:0] cmpa;
   logic [15:0] cmpb;
   logic [15:0] capt;
   logic [3:0] flags;
   logic [1:0] latch;
   logic block;
   logic wr_en;
   logic rd_en;
   logic addr_ok;
   logic cnt_wr;
   logic [1:0] force_s;
   logic run;
   logic match_a;
   logic match_b;
   logic top_hit;
   logic wrap;
   logic [3:0] flag_set;
   logic [3:0] flag_clr;
   logic [31:0] rd_mux;

   // ==========================================================
   // APB slave: one wait cycle, then pready for one cycle

   assign wr_en = psel_i && penable_i && pready_o && pwrite_i;
   assign rd_en = psel_i && penable_i && !pready_o;

   // Address decode shared by read mux and error answer
   always_comb
   begin
      addr_ok = 1'b1;
      rd_mux = tcm_pkg::RDATA_RST;
      case (paddr_i)
         tcm_pkg::ADDR_CTRL: rd_mux[7:0] = ctrl;
         tcm_pkg::ADDR_COUNT: rd_mux[15:0] = count;
         tcm_pkg::ADDR_CMPA: rd_mux[15:0] = cmpa;
         tcm_pkg::ADDR_CMPB: rd_mux[15:0] = cmpb;
         tcm_pkg::ADDR_CAPT: rd_mux[15:0] = capt;
         tcm_pkg::ADDR_FLAGS: rd_mux[3:0] = flags;
         tcm_pkg::ADDR_FORCE: rd_mux = tcm_pkg::RDATA_RST; // Strobes read zero
         tcm_pkg::ADDR_PORT: rd_mux[3:0] = port;
         default: addr_ok = 1'b0;
      endcase
   end

   // Handshake sequencer
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         bus_state <= tcm_pkg::BUS_IDLE;
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= tcm_pkg::RDATA_RST;
      end
      else
      begin
         case (bus_state)
            tcm_pkg::BUS_IDLE:
            begin
               if (rd_en)
               begin
                  bus_state <= tcm_pkg::BUS_DONE;
                  pready_o <= 1'b1;
                  pslverr_o <= !addr_ok;
                  prdata_o <= rd_mux;
               end
            end
            tcm_pkg::BUS_DONE:
            begin
               bus_state <= tcm_pkg::BUS_IDLE;
               pready_o <= 1'b0;
               pslverr_o <= 1'b0;
            end
            default:
            begin
               bus_state <= tcm_pkg::BUS_IDLE;
               pready_o <= 1'b0;
               pslverr_o <= 1'b0;
            end
         endcase
      end
   end

   assign cnt_wr = wr_en && (paddr_i == tcm_pkg::ADDR_COUNT);

   // Force strobes only act in the modes this block runs
   assign force_s = (wr_en && (paddr_i == tcm_pkg::ADDR_FORCE) && non_pwm(ctrl.mode)) ? pwdata_i[1:0] : 2'b00;

   // ==========================================================
   // Configuration registers

   // Unbuffered: top and compare values take effect at once
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         ctrl <= '0;
         port <= '0;
         cmpa <= tcm_pkg::CNT_ZERO;
         cmpb <= tcm_pkg::CNT_ZERO;
         capt <= tcm_pkg::CNT_ZERO;
      end
      else if (wr_en)
      begin
         case (paddr_i)
            tcm_pkg::ADDR_CTRL: ctrl <= pwdata_i[7:0];
            tcm_pkg::ADDR_CMPA: cmpa <= pwdata_i[15:0];
            tcm_pkg::ADDR_CMPB: cmpb <= pwdata_i[15:0];
            tcm_pkg::ADDR_CAPT: capt <= pwdata_i[15:0];
            tcm_pkg::ADDR_PORT: port <= pwdata_i[3:0];
            default: port <= port;
         endcase
      end
   end

   // ==========================================================
   // Counter

   assign run = timer_tick_i && non_pwm(ctrl.mode);
   assign match_a = run && !block && (count == cmpa);
   assign match_b = run && !block && (count == cmpb);

   // Top from compare A in mode 4, capture value in mode 12
   always_comb
   begin
      top_hit = 1'b0;
      if (ctrl.mode == tcm_pkg::MODE_CTC_CMPA)
      begin
         top_hit = match_a;
      end
      else if (ctrl.mode == tcm_pkg::MODE_CTC_CAPT)
      begin
         top_hit = run && !block && (count == capt);
      end
   end

   assign wrap = run && !top_hit && (count == tcm_pkg::CNT_MAX);

   // Software write wins over counting and arms the match block
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         count <= tcm_pkg::CNT_ZERO;
      end
      else if (cnt_wr)
      begin
         count <= pwdata_i[15:0];
      end
      else if (top_hit)
      begin
         count <= tcm_pkg::CNT_ZERO;
      end
      else if (run)
      begin
         count <= count + tcm_pkg::CNT_ONE;
      end
   end

   // Block lasts until the next timer tick, even when stopped
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         block <= 1'b0;
      end
      else if (cnt_wr)
      begin
         block <= 1'b1;
      end
      else if (timer_tick_i)
      begin
         block <= 1'b0;
      end
   end

   // ==========================================================
   // Flags: hardware set beats a same-cycle clear

   always_comb
   begin
      flag_set = 4'h0;
      flag_set[tcm_pkg::FLG_OVF] = wrap;
      flag_set[tcm_pkg::FLG_CMPA] = match_a;
      flag_set[tcm_pkg::FLG_CMPB] = match_b;
      flag_set[tcm_pkg::FLG_CAPT] = top_hit && (ctrl.mode == tcm_pkg::MODE_CTC_CAPT);
      flag_clr = isr_ack_i;
      if (wr_en && (paddr_i == tcm_pkg::ADDR_FLAGS))
      begin
         flag_clr = flag_clr | pwdata_i[3:0];
      end
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         flags <= tcm_pkg::FLAGS_RST;
      end
      else
      begin
         flags <= (flags & ~flag_clr) | flag_set;
      end
   end

   // ==========================================================
   // Output latches: compare match or force, action read live

   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         latch <= tcm_pkg::LATCH_RST;
      end
      else
      begin
         if (match_a || force_s[0])
         begin
            latch[0] <= apply_act(ctrl.act_a, latch[0]);
         end
         if (match_b || force_s[1])
         begin
            latch[1] <= apply_act(ctrl.act_b, latch[1]);
         end
      end
   end

   // Pin stage: one register so every output is a flop
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         oc_pin_o <= 2'b00;
         oc_pin_oe_o <= 2'b00;
         flags_o <= tcm_pkg::FLAGS_RST;
      end
      else
      begin
         oc_pin_o[0] <= (ctrl.act_a != tcm_pkg::ACT_NONE) ? latch[0] : port.out[0];
         oc_pin_o[1] <= (ctrl.act_b != tcm_pkg::ACT_NONE) ? latch[1] : port.out[1];
         oc_pin_oe_o <= port.dir;
         flags_o <= flags;
      end
   end
   // Capture logic lives elsewhere and sees no action bits

   // ==========================================================
   // Assertions

   sequence s_access;
      psel_i && penable_i && !pready_o && bus_state == tcm_pkg::BUS_IDLE;
   endsequence

   sequence s_answer;
      pready_o ##1 !pready_o;
   endsequence

   a_apb_answer: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      s_access |=> s_answer)
      else $error("APB answer not one cycle late");

   a_pin_override: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      ctrl.act_a != tcm_pkg::ACT_NONE |=> oc_pin_o[0] == $past(latch[0]))
      else $error("Pin not driven from latch");

   a_pin_dir: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      oc_pin_oe_o == $past(port.dir))
      else $error("Pin enable not from direction bit");

   a_none_holds: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      ctrl.act_a == tcm_pkg::ACT_NONE |=> latch[0] == $past(latch[0]))
      else $error("Latch changed with no action");

   a_normal_wrap: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      run && ctrl.mode == tcm_pkg::MODE_NORMAL && count == tcm_pkg::CNT_MAX && !cnt_wr
      |=> count == tcm_pkg::CNT_ZERO && flags[tcm_pkg::FLG_OVF])
      else $error("Normal mode wrap or overflow flag wrong");

   a_ctc_clear: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      run && !block && ctrl.mode == tcm_pkg::MODE_CTC_CMPA && count == cmpa && !cnt_wr
      |=> count == tcm_pkg::CNT_ZERO && flags[tcm_pkg::FLG_CMPA])
      else $error("Clear on compare A failed");

   a_block_arm: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      cnt_wr |=> block)
      else $error("Counter write did not arm match block");

   a_write_block: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      block && timer_tick_i && !cnt_wr && ctrl.mode == tcm_pkg::MODE_CTC_CMPA
      |=> count == 16'($past(count) + tcm_pkg::CNT_ONE))
      else $error("Match not blocked after counter write");

   a_toggle_match: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      match_a && ctrl.act_a == tcm_pkg::ACT_TOGGLE |=> latch[0] != $past(latch[0]))
      else $error("Toggle did not invert latch");

   a_force_only: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      force_s[0] && !timer_tick_i && !cnt_wr && !flags[tcm_pkg::FLG_CMPA]
      |=> count == $past(count) && !flags[tcm_pkg::FLG_CMPA])
      else $error("Force disturbed counter or flag");

   a_ack_clears: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      isr_ack_i[tcm_pkg::FLG_OVF] && !wrap |=> !flags[tcm_pkg::FLG_OVF])
      else $error("Overflow flag not cleared by ack");

endmodule
